// ==== dv/cal_step_nvm_model.sv ====
`timescale 1ns/1ps
module cal_step_nvm_model (
    input  wire logic       aclk,
    input  wire logic       cal_step_go_ff,
    input  wire logic [7:0] cal_step_num_ff,
    input  wire logic       nvm_write_ff,
    input  wire logic [7:0] fail_step,
    input  wire logic [7:0] fail_code,
    output logic            cal_step_done = 1'h0,
    output logic [7:0]      cal_step_error = 8'h00,
    output logic            nvm_done = 1'h0
);
    int         cnt = 0;
    logic [3:0] ack = '0;
    // later steps take longer; error settles long before done rises
    always @(posedge aclk) begin
        if (cal_step_go_ff) begin
            cnt <= 8 + cal_step_num_ff;
            cal_step_error <= cal_step_num_ff == fail_step ? fail_code : 8'h00;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        cal_step_done <= cnt inside {[1:3]};
        ack <= {ack[2:0], nvm_write_ff};
        nvm_done <= ack[3] && nvm_write_ff;
    end
endmodule

// ==== dv/self_cal_and_run_mode_control_properties.sv ====
`timescale 1ns/1ps
module self_cal_and_run_mode_control_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        cal_step_done,
    input wire logic [7:0]  cal_step_error,
    input wire logic [7:0]  cal_step_num_ff,
    input wire logic        cal_step_go_ff,
    input wire logic        nvm_write_ff,
    input wire logic        nvm_done,
    input wire logic [11:0] amp_offset_dac_ff,
    input wire logic [11:0] mod_zero_dac_ff,
    input wire logic [11:0] ofs_pos_dac_ff,
    input wire logic [11:0] ofs_neg_dac_ff,
    input wire logic [11:0] preamp_zero_dac_ff,
    input wire logic [11:0] sc_zero_dac_ff,
    input wire logic [19:0] amp_gain_out_ff,
    input wire logic [19:0] ofs_gain_out_ff,
    input wire logic [15:0] freq_gain_ff,
    input wire logic        wave_out_en_ff
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_pass;
        $rose(cal_step_done) && cal_step_error == 8'h00;
    endsequence
    sequence s_fail;
        $rose(cal_step_done) && cal_step_error != 8'h00;
    endsequence
    property p_dac_rst;
        $rose(aresetn) |-> {amp_offset_dac_ff, mod_zero_dac_ff, ofs_pos_dac_ff,
            ofs_neg_dac_ff, preamp_zero_dac_ff, sc_zero_dac_ff} == {6{12'h800}};
    endproperty
    property p_gain_rst;
        $rose(aresetn) |-> amp_gain_out_ff == 20'h00000
            && ofs_gain_out_ff == 20'h00000 && freq_gain_ff == 16'h1000;
    endproperty
    property p_run_default;
        $rose(aresetn) |-> ##[1:3] wave_out_en_ff;
    endproperty
    property p_go_pulse;
        cal_step_go_ff |=> !cal_step_go_ff;
    endproperty
    property p_step_up;
        $changed(cal_step_num_ff) && cal_step_num_ff != 8'h00 |->
            cal_step_num_ff == $past(cal_step_num_ff) + 8'h01
            || cal_step_num_ff == 8'h01;
    endproperty
    property p_advance;
        s_pass ##0 cal_step_num_ff < 8'h06 |-> ##[1:12] cal_step_go_ff;
    endproperty
    property p_last_pass;
        s_pass ##0 cal_step_num_ff == 8'h06 |-> ##[1:12] nvm_write_ff;
    endproperty
    property p_fail_stop;
        s_fail |-> (!cal_step_go_ff && !nvm_write_ff)[*8];
    endproperty
    property p_nvm_hold;
        nvm_write_ff && !nvm_done |=> nvm_write_ff;
    endproperty
    a_dac_rst: assert property (p_dac_rst)
        else $error("correction dac not at its default after reset");
    a_gain_rst: assert property (p_gain_rst)
        else $error("gain outputs not at default after reset");
    a_run_default: assert property (p_run_default)
        else $error("output not running after reset");
    a_go_pulse: assert property (p_go_pulse)
        else $error("step start longer than one cycle");
    a_step_up: assert property (p_step_up)
        else $error("step number not ascending");
    a_advance: assert property (p_advance)
        else $error("passed step not followed by next step");
    a_last_pass: assert property (p_last_pass)
        else $error("passing calibration not saved");
    a_fail_stop: assert property (p_fail_stop)
        else $error("failed calibration went on or saved");
    a_nvm_hold: assert property (p_nvm_hold)
        else $error("storage write dropped before acknowledge");
endmodule

// ==== dv/self_cal_and_run_mode_control_tb.sv ====
`timescale 1ns/1ps
module self_cal_and_run_mode_control_tb;
    logic        aclk = 1'h0, aresetn = 1'h0, trig_in = 1'h0;
    logic        wave_cycle_end = 1'h0, s_axi_awvalid = 1'h0;
    logic        s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, v [6];
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, cal_step_done, nvm_done, cal_step_go_ff;
    logic        nvm_write_ff, wave_out_en_ff;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  cal_step_error, cal_step_num_ff, fail_step = '0, fail_code = '0;
    logic [11:0] amp_offset_dac_ff, mod_zero_dac_ff, ofs_pos_dac_ff;
    logic [11:0] ofs_neg_dac_ff, preamp_zero_dac_ff, sc_zero_dac_ff;
    logic [19:0] amp_gain_out_ff, ofs_gain_out_ff;
    logic [15:0] freq_gain_ff, ft [6] = '{16'h0000, 16'h1B58, 16'h32C8,
                                          16'h4268, 16'h4E20, 16'h61A8};
    logic [7:0]  da [6] = '{8'h10, 8'h14, 8'h1C, 8'h20, 8'h24, 8'h28};
    logic [32:0] e, expq [$];
    int          failures = 0, n_checks = 0, nvm_cnt = 0, i;
    int          seed = 32'hC4C3A672;
    always #20 aclk = ~aclk;
    self_cal_and_run_mode_control dut (.*);
    cal_step_nvm_model partner (.*);
    always @(posedge nvm_write_ff) nvm_cnt++;
    always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) begin
        e = expq.pop_front();
        if (e[32]) chk("rdata", s_axi_rdata, e[31:0]);
    end
    task automatic chk(input string nm, input logic [31:0] s, x);
        n_checks++;
        if (s !== x) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= w; s_axi_bready <= 1'h1;
        s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
        for (n = 0; n < 100 && !s_axi_bvalid; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        if (n == 100) begin failures++; test_done(); end
    endtask
    task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] x);
        int n;
        expq.push_back({c, x});
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        for (n = 0; n < 100 && !(s_axi_rvalid && n > 0); n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        d = s_axi_rdata; s_axi_rready <= 1'h0;
        if (n == 100) begin failures++; test_done(); end
    endtask
    task automatic idle();
        for (int n = 0; n < 300; n++) begin
            rd(8'h04, 1'h0, '0);
            if (d[1:0] === 2'h0) return;
        end
        failures++; test_done();
    endtask
    task automatic wt_out(input logic x);
        for (int n = 0; n < 40 && wave_out_en_ff !== x; n++) @(posedge aclk);
        chk("wave_out_en", wave_out_en_ff, x);
    endtask
    initial begin
        repeat (100000) @(posedge aclk);
        failures++; test_done();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 6; i++) rd(da[i], 1'h1, 32'h800);
        for (i = 0; i < 6; i++) rd(8'h40 + 4 * i, 1'h1, {ft[i], 16'h1000});
        rd(8'h0C, 1'h1, 0); rd(8'h18, 1'h1, 0); rd(8'h3C, 1'h1, 0);
        rd(8'h34, 1'h1, 32'h1000); rd(8'h00, 1'h1, 32'hC);
        wr(8'h44, {ft[1], 16'h1000}); wr(8'h48, {ft[2], 16'h1200});
        wr(8'h30, 32'h2710);
        for (i = 0; i < 6; i++) begin
            v[i] = $random(seed) & 32'hFFF;
            wr(da[i], v[i]); rd(da[i], 1'h1, v[i]);
        end
        rd(8'h34, 1'h1, 32'h1100); chk("freq_gain", freq_gain_ff, 16'h1100);
        chk("dacs", {mod_zero_dac_ff, preamp_zero_dac_ff, sc_zero_dac_ff},
            {v[1][11:0], v[4][11:0], v[5][11:0]});
        v[0] = $random(seed) & 32'h1FFFF;
        wr(8'h0C, 32'hFFFFF); wr(8'h18, v[0]); rd(8'h18, 1'h1, v[0]);
        rd(8'h0C, 1'h1, 32'h3E800); chk("gain", amp_gain_out_ff, 20'h3E800);
        wr(8'h00, 32'hE); idle(); chk("commit", nvm_cnt, 1);
        wr(8'h00, 32'hD); idle(); rd(8'h08, 1'h1, 0);
        rd(8'h04, 1'h1, 32'hC); chk("save", nvm_cnt, 2);
        fail_step <= 8'h03; fail_code <= ($random(seed) & 8'hFF) | 8'h01;
        wr(8'h00, 32'hD); idle(); rd(8'h00, 1'h1, 32'h8);
        rd(8'h08, 1'h1, {fail_code, 8'h03}); chk("save", nvm_cnt, 2);
        wr(8'h2C, 32'h2); wr(8'h00, 32'h4); wt_out(1'h0);
        trig_in <= 1'h1; wt_out(1'h1); trig_in <= 1'h0;
        for (i = 0; i < 2; i++) begin
            repeat (6) @(posedge aclk);
            chk("burst", wave_out_en_ff, 1);
            wave_cycle_end <= 1'h1; repeat (4) @(posedge aclk);
            wave_cycle_end <= 1'h0;
        end
        wt_out(1'h0); wr(8'h00, 32'h24); wt_out(1'h1);
        wr(8'h00, 32'h14); wt_out(1'h0);
        trig_in <= 1'h1; wt_out(1'h1); trig_in <= 1'h0; wt_out(1'h0);
        wr(8'h00, 32'hC); wt_out(1'h1);
        test_done();
    end
endmodule
bind self_cal_and_run_mode_control
    self_cal_and_run_mode_control_properties props (.*);

// ==== hdl/cal_ctrl_defs.svh ====
`ifndef CAL_CTRL_DEFS_SVH
`define CAL_CTRL_DEFS_SVH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_CAL_RESULT  8'h08
`define REG_AMP_GAIN    8'h0C
`define REG_AMP_OFFSET  8'h10
`define REG_MOD_ZERO    8'h14
`define REG_OFS_GAIN    8'h18
`define REG_OFS_POS     8'h1C
`define REG_OFS_NEG     8'h20
`define REG_PREAMP_ZERO 8'h24
`define REG_SC_ZERO     8'h28
`define REG_TRIG_COUNT  8'h2C
`define REG_OUT_FREQ    8'h30
`define REG_CUR_GAIN    8'h34
`define REG_TBL_BASE    8'h40
`define REG_TBL_LAST    8'h54

// control register fields
`define CTRL_START_CAL  0
`define CTRL_COMMIT     1
`define CTRL_CORR_EN    2
`define CTRL_CONT       3
`define CTRL_GATE       4
`define CTRL_SOFT_TRIG  5
`define CTRL_RESET      32'h0000_000C

// status register fields
`define STAT_CAL_BUSY   0
`define STAT_COMMIT_BSY 1
`define STAT_OUT_EN     2
`define STAT_CAL_OK     3

// value widths and defaults
`define DAC_DEFAULT     12'h800
`define GAIN_DEFAULT    20'h00000
`define UNITY_GAIN      16'h1000
`define GAIN_MAX        20'h3E800
`define DAC_MAX         12'hFFF
`define CAL_LAST_STEP   8'h06
`define TBL_ENTRIES     6
`define FREQ_F0         16'h0000
`define FREQ_F1         16'h1B58
`define FREQ_F2         16'h32C8
`define FREQ_F3         16'h4268
`define FREQ_F4         16'h4E20
`define FREQ_F5         16'h61A8
`define TRIG_COUNT_DEF  20'h00001
`define AXI_OKAY        2'h0
`define AXI_SLVERR      2'h2

`endif

// ==== hdl/cal_ctrl_pkg.sv ====
package cal_ctrl_pkg;
    typedef enum logic [2:0] {
        CAL_IDLE   = 3'b000,
        CAL_STEP   = 3'b001,
        CAL_PASS   = 3'b010,
        CAL_FAIL   = 3'b011,
        CAL_COMMIT = 3'b100
    } cal_state_t;

    typedef enum logic [1:0] {
        RUN_CONT  = 2'b00,
        RUN_TRIG  = 2'b01,
        RUN_GATED = 2'b10
    } run_mode_t;
endpackage

// ==== hdl/self_cal_and_run_mode_control.sv ====
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "cal_ctrl_defs.svh"
module self_cal_and_run_mode_control (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cal_step_done,
    input  wire logic [7:0]  cal_step_error,
    input  wire logic        trig_in,
    input  wire logic        wave_cycle_end,
    output logic [7:0]       cal_step_num_ff,
    output logic             cal_step_go_ff,
    output logic             nvm_write_ff,
    input  wire logic        nvm_done,
    output logic [11:0]      amp_offset_dac_ff,
    output logic [11:0]      mod_zero_dac_ff,
    output logic [11:0]      ofs_pos_dac_ff,
    output logic [11:0]      ofs_neg_dac_ff,
    output logic [11:0]      preamp_zero_dac_ff,
    output logic [11:0]      sc_zero_dac_ff,
    output logic [19:0]      amp_gain_out_ff,
    output logic [19:0]      ofs_gain_out_ff,
    output logic [15:0]      freq_gain_ff,
    output logic             wave_out_en_ff
);
    // corrections used when the stored data is disabled
    localparam logic [11:0] DAC_DEF = `DAC_DEFAULT;

    cal_ctrl_pkg::cal_state_t cal_st_ff;
    cal_ctrl_pkg::run_mode_t  mode;
    logic [31:0] ctrl_ff;
    logic [15:0] cal_result_ff;
    logic        cal_ok_ff;
    logic [19:0] amp_gain_ff, ofs_gain_ff, trig_count_ff, cyc_left_ff;
    logic [11:0] amp_ofs_ff, mod_zero_ff, ofs_pos_ff, ofs_neg_ff;
    logic [11:0] preamp_zero_ff, sc_zero_ff;
    logic [15:0] out_freq_ff;
    logic [15:0] tbl_freq_ff [0:5];
    logic [15:0] tbl_gain_ff [0:5];
    logic [7:0]  aw_addr_ff;
    logic [31:0] w_data_ff;
    logic        aw_have_ff, w_have_ff;
    logic        wr_go, start_pulse, commit_pulse, trig_pulse;
    logic        trig_m_ff, trig_s_ff, trig_d_ff;
    logic        cyc_m_ff, cyc_s_ff, cyc_d_ff, cyc_edge;
    logic        done_m_ff, done_s_ff, done_d_ff, done_edge;
    logic        nvd_m_ff, nvd_s_ff;
    logic [7:0]  err_m_ff, err_s_ff;

    function automatic logic [11:0] clamp12(input logic [31:0] v);
        clamp12 = v[11:0];
    endfunction

    function automatic logic [19:0] clamp_gain(input logic [31:0] v);
        clamp_gain = (v[19:0] > `GAIN_MAX || v[31:20] != 12'h000)
                     ? `GAIN_MAX : v[19:0];
    endfunction

    function automatic logic is_tbl(input logic [7:0] a);
        is_tbl = (a >= `REG_TBL_BASE) && (a <= `REG_TBL_LAST);
    endfunction

    // pins from outside the clock domain pass two flops first
    always_ff @(posedge aclk) begin
        trig_m_ff <= trig_in;
        trig_s_ff <= trig_m_ff;
        trig_d_ff <= trig_s_ff;
        cyc_m_ff  <= wave_cycle_end;
        cyc_s_ff  <= cyc_m_ff;
        cyc_d_ff  <= cyc_s_ff;
        done_m_ff <= cal_step_done;
        done_s_ff <= done_m_ff;
        done_d_ff <= done_s_ff;
        nvd_m_ff  <= nvm_done;
        nvd_s_ff  <= nvd_m_ff;
        err_m_ff  <= cal_step_error;
        err_s_ff  <= err_m_ff;
    end
    assign cyc_edge  = cyc_s_ff & ~cyc_d_ff;
    assign done_edge = done_s_ff & ~done_d_ff;

    // write channel: address and data taken in either order
    assign s_axi_awready = ~aw_have_ff & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_ff & ~s_axi_bvalid;
    assign wr_go = aw_have_ff & w_have_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_have_ff   <= 1'b0;
                w_have_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_ff <= `REG_CUR_GAIN
                                 || is_tbl(aw_addr_ff))
                                ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // command pulses; start and commit ignored while calibration is busy
    assign start_pulse  = wr_go && aw_addr_ff == `REG_CTRL
                          && w_data_ff[`CTRL_START_CAL]
                          && cal_st_ff == cal_ctrl_pkg::CAL_IDLE;
    assign commit_pulse = wr_go && aw_addr_ff == `REG_CTRL
                          && w_data_ff[`CTRL_COMMIT]
                          && cal_st_ff == cal_ctrl_pkg::CAL_IDLE;
    assign trig_pulse   = (trig_s_ff & ~trig_d_ff)
                          | (wr_go && aw_addr_ff == `REG_CTRL
                             && w_data_ff[`CTRL_SOFT_TRIG]);

    // correction values, written directly by register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff        <= `CTRL_RESET;
            amp_gain_ff    <= `GAIN_DEFAULT;
            amp_ofs_ff     <= `DAC_DEFAULT;
            mod_zero_ff    <= `DAC_DEFAULT;
            ofs_gain_ff    <= `GAIN_DEFAULT;
            ofs_pos_ff     <= `DAC_DEFAULT;
            ofs_neg_ff     <= `DAC_DEFAULT;
            preamp_zero_ff <= `DAC_DEFAULT;
            sc_zero_ff     <= `DAC_DEFAULT;
            trig_count_ff  <= `TRIG_COUNT_DEF;
            out_freq_ff    <= 16'h0000;
        end else if (wr_go) begin
            case (aw_addr_ff)
                `REG_CTRL:        ctrl_ff <= {26'h0, 1'b0, w_data_ff[4:2], 2'b00};
                `REG_AMP_GAIN:    amp_gain_ff    <= clamp_gain(w_data_ff);
                `REG_AMP_OFFSET:  amp_ofs_ff     <= clamp12(w_data_ff);
                `REG_MOD_ZERO:    mod_zero_ff    <= clamp12(w_data_ff);
                `REG_OFS_GAIN:    ofs_gain_ff    <= clamp_gain(w_data_ff);
                `REG_OFS_POS:     ofs_pos_ff     <= clamp12(w_data_ff);
                `REG_OFS_NEG:     ofs_neg_ff     <= clamp12(w_data_ff);
                `REG_PREAMP_ZERO: preamp_zero_ff <= clamp12(w_data_ff);
                `REG_SC_ZERO:     sc_zero_ff     <= clamp12(w_data_ff);
                `REG_TRIG_COUNT:  trig_count_ff  <= (w_data_ff[19:0] == 20'h0)
                                  ? `TRIG_COUNT_DEF : w_data_ff[19:0];
                `REG_OUT_FREQ:    out_freq_ff    <= w_data_ff[15:0];
                default: ;
            endcase
        end
        if (aresetn && cal_st_ff == cal_ctrl_pkg::CAL_PASS) begin
            ctrl_ff[`CTRL_CORR_EN] <= 1'b1;
        end else if (aresetn && cal_st_ff == cal_ctrl_pkg::CAL_FAIL) begin
            ctrl_ff[`CTRL_CORR_EN] <= 1'b0;
        end
    end

    // frequency/gain table: each word is {freq[31:16], gain[15:0]}
    genvar gi;
    generate
        for (gi = 0; gi < `TBL_ENTRIES; gi++) begin : g_tbl
            localparam logic [7:0] ADDR = 8'(`REG_TBL_BASE + 4 * gi);
            localparam logic [15:0] FDEF = (gi == 0) ? `FREQ_F0 :
                (gi == 1) ? `FREQ_F1 : (gi == 2) ? `FREQ_F2 :
                (gi == 3) ? `FREQ_F3 : (gi == 4) ? `FREQ_F4 : `FREQ_F5;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    tbl_freq_ff[gi] <= FDEF;
                    tbl_gain_ff[gi] <= `UNITY_GAIN;
                end else if (wr_go && aw_addr_ff == ADDR) begin
                    tbl_freq_ff[gi] <= w_data_ff[31:16];
                    tbl_gain_ff[gi] <= w_data_ff[15:0];
                end
            end
        end
    endgenerate

    // interpolation: find segment, then one multiply and divide per clock
    logic [2:0]  seg;
    logic [15:0] f_lo, f_hi, g_lo, g_hi, df, dx;
    logic signed [17:0] dg;
    logic signed [35:0] prod;
    logic [15:0] interp;
    always_comb begin
        seg = 3'd0;
        for (int i = 1; i < `TBL_ENTRIES - 1; i++) begin
            if (out_freq_ff >= tbl_freq_ff[i]) seg = 3'(i);
        end
        f_lo = tbl_freq_ff[seg];
        f_hi = tbl_freq_ff[seg + 3'd1];
        g_lo = tbl_gain_ff[seg];
        g_hi = tbl_gain_ff[seg + 3'd1];
        df   = f_hi - f_lo;
        dx   = (out_freq_ff > f_hi) ? df : out_freq_ff - f_lo;
        dg   = $signed({2'b00, g_hi}) - $signed({2'b00, g_lo});
        prod = dg * $signed({2'b00, dx});
        if (df == 16'h0000) interp = g_lo;
        else interp = 16'($signed({2'b00, g_lo}) + prod / $signed({2'b00, df}));
    end

    // calibration sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_st_ff       <= cal_ctrl_pkg::CAL_IDLE;
            cal_step_num_ff <= 8'h00;
            cal_step_go_ff  <= 1'b0;
            cal_result_ff   <= 16'h0000;
            cal_ok_ff       <= 1'b0;
            nvm_write_ff    <= 1'b0;
        end else begin
            cal_step_go_ff <= 1'b0;
            case (cal_st_ff)
                cal_ctrl_pkg::CAL_IDLE: begin
                    if (start_pulse) begin
                        cal_step_num_ff <= 8'h01;
                        cal_step_go_ff  <= 1'b1;
                        cal_st_ff       <= cal_ctrl_pkg::CAL_STEP;
                    end else if (commit_pulse) begin
                        nvm_write_ff <= 1'b1;
                        cal_st_ff    <= cal_ctrl_pkg::CAL_COMMIT;
                    end
                end
                cal_ctrl_pkg::CAL_STEP: begin
                    if (done_edge) begin
                        if (err_s_ff != 8'h00) begin
                            cal_result_ff <= {err_s_ff, cal_step_num_ff};
                            cal_st_ff     <= cal_ctrl_pkg::CAL_FAIL;
                        end else if (cal_step_num_ff == `CAL_LAST_STEP) begin
                            cal_result_ff <= 16'h0000;
                            cal_st_ff     <= cal_ctrl_pkg::CAL_PASS;
                        end else begin
                            cal_step_num_ff <= cal_step_num_ff + 8'h01;
                            cal_step_go_ff  <= 1'b1;
                        end
                    end
                end
                cal_ctrl_pkg::CAL_PASS: begin
                    cal_ok_ff    <= 1'b1;
                    nvm_write_ff <= 1'b1;
                    cal_st_ff    <= cal_ctrl_pkg::CAL_COMMIT;
                end
                cal_ctrl_pkg::CAL_FAIL: begin
                    cal_ok_ff <= 1'b0;
                    cal_st_ff <= cal_ctrl_pkg::CAL_IDLE;
                end
                cal_ctrl_pkg::CAL_COMMIT: begin
                    if (nvd_s_ff) begin
                        nvm_write_ff <= 1'b0;
                        cal_st_ff    <= cal_ctrl_pkg::CAL_IDLE;
                    end
                end
                default: cal_st_ff <= cal_ctrl_pkg::CAL_IDLE;
            endcase
        end
    end

    // outputs apply stored values only while corrections are enabled, except the mod, preamp and sc zero DACs, which always do
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            amp_offset_dac_ff  <= `DAC_DEFAULT;
            mod_zero_dac_ff    <= `DAC_DEFAULT;
            ofs_pos_dac_ff     <= `DAC_DEFAULT;
            ofs_neg_dac_ff     <= `DAC_DEFAULT;
            preamp_zero_dac_ff <= `DAC_DEFAULT;
            sc_zero_dac_ff     <= `DAC_DEFAULT;
            amp_gain_out_ff    <= `GAIN_DEFAULT;
            ofs_gain_out_ff    <= `GAIN_DEFAULT;
            freq_gain_ff       <= `UNITY_GAIN;
        end else begin
            mod_zero_dac_ff    <= mod_zero_ff;
            preamp_zero_dac_ff <= preamp_zero_ff;
            sc_zero_dac_ff     <= sc_zero_ff;
            if (ctrl_ff[`CTRL_CORR_EN]) begin
                amp_offset_dac_ff <= amp_ofs_ff;
                ofs_pos_dac_ff    <= ofs_pos_ff;
                ofs_neg_dac_ff    <= ofs_neg_ff;
                amp_gain_out_ff   <= amp_gain_ff;
                ofs_gain_out_ff   <= ofs_gain_ff;
                freq_gain_ff      <= interp;
            end else begin
                amp_offset_dac_ff <= DAC_DEF;
                ofs_pos_dac_ff    <= DAC_DEF;
                ofs_neg_dac_ff    <= DAC_DEF;
                amp_gain_out_ff   <= `GAIN_DEFAULT;
                ofs_gain_out_ff   <= `GAIN_DEFAULT;
                freq_gain_ff      <= `UNITY_GAIN;
            end
        end
    end

    // run mode
    always_comb begin
        if (ctrl_ff[`CTRL_CONT]) mode = cal_ctrl_pkg::RUN_CONT;
        else if (ctrl_ff[`CTRL_GATE]) mode = cal_ctrl_pkg::RUN_GATED;
        else mode = cal_ctrl_pkg::RUN_TRIG;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_left_ff    <= 20'h00000;
            wave_out_en_ff <= 1'b0;
        end else begin
            case (mode)
                cal_ctrl_pkg::RUN_CONT: begin
                    cyc_left_ff    <= 20'h00000;
                    wave_out_en_ff <= 1'b1;
                end
                cal_ctrl_pkg::RUN_GATED: begin
                    cyc_left_ff    <= 20'h00000;
                    wave_out_en_ff <= trig_s_ff;
                end
                cal_ctrl_pkg::RUN_TRIG: begin
                    // a trigger during a burst is ignored until it ends
                    if (cyc_left_ff == 20'h00000) begin
                        if (trig_pulse) begin
                            cyc_left_ff    <= trig_count_ff;
                            wave_out_en_ff <= 1'b1;
                        end else begin
                            wave_out_en_ff <= 1'b0;
                        end
                    end else if (cyc_edge) begin
                        cyc_left_ff <= cyc_left_ff - 20'h00001;
                        if (cyc_left_ff == 20'h00001) wave_out_en_ff <= 1'b0;
                    end
                end
                default: wave_out_en_ff <= 1'b0;
            endcase
        end
    end

    // read channel, one cycle after address is taken
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `AXI_OKAY;
            case (s_axi_araddr)
                `REG_CTRL:        s_axi_rdata <= ctrl_ff;
                `REG_STATUS:      s_axi_rdata <= {28'h0, cal_ok_ff,
                    wave_out_en_ff,
                    cal_st_ff == cal_ctrl_pkg::CAL_COMMIT,
                    cal_st_ff inside {cal_ctrl_pkg::CAL_STEP,
                        cal_ctrl_pkg::CAL_PASS, cal_ctrl_pkg::CAL_FAIL}};
                `REG_CAL_RESULT:  s_axi_rdata <= {16'h0, cal_result_ff};
                `REG_AMP_GAIN:    s_axi_rdata <= {12'h0, amp_gain_ff};
                `REG_AMP_OFFSET:  s_axi_rdata <= {20'h0, amp_ofs_ff};
                `REG_MOD_ZERO:    s_axi_rdata <= {20'h0, mod_zero_ff};
                `REG_OFS_GAIN:    s_axi_rdata <= {12'h0, ofs_gain_ff};
                `REG_OFS_POS:     s_axi_rdata <= {20'h0, ofs_pos_ff};
                `REG_OFS_NEG:     s_axi_rdata <= {20'h0, ofs_neg_ff};
                `REG_PREAMP_ZERO: s_axi_rdata <= {20'h0, preamp_zero_ff};
                `REG_SC_ZERO:     s_axi_rdata <= {20'h0, sc_zero_ff};
                `REG_TRIG_COUNT:  s_axi_rdata <= {12'h0, trig_count_ff};
                `REG_OUT_FREQ:    s_axi_rdata <= {16'h0, out_freq_ff};
                `REG_CUR_GAIN:    s_axi_rdata <= {16'h0, freq_gain_ff};
                default: begin
                    if (is_tbl(s_axi_araddr)) begin
                        s_axi_rdata <= {tbl_freq_ff[3'(s_axi_araddr[4:2] + 3'd0)],
                                        tbl_gain_ff[3'(s_axi_araddr[4:2])]};
                    end else begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `AXI_SLVERR;
                    end
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
